// ---- mcr_cfg.svh ----
// Offsets, field positions and fixed values of the commutation
// register block. Definitions only; included by the package.
`ifndef MCR_CFG_SVH
`define MCR_CFG_SVH

// Word index of each register (byte address is index times four)
`define MCR_IDX_NCOMP   3'h0
`define MCR_IDX_DEMAG   3'h1
`define MCR_IDX_WEIGHT  3'h2
`define MCR_IDX_PRESC   3'h3
`define MCR_IDX_IRQEN   3'h4
`define MCR_IDX_FLAGS   3'h5
`define MCR_IDX_CTRL    3'h6
`define MCR_IDX_AUX     3'h7

// Reset value of every register
`define MCR_RST_BYTE    8'h00
// Flag write value that resynchronises the PWM generator
`define MCR_RESYNC_VAL  8'hFF

// Flag and enable bit positions
`define MCR_B_PWM       7
`define MCR_B_SPEED     6
`define MCR_B_UP        6
`define MCR_B_DOWN      5
`define MCR_B_CURRENT_LIMIT_IRQ_ENABLE      4
`define MCR_B_EMER      3
`define MCR_B_ZERO      2
`define MCR_B_DEMAG     1
`define MCR_B_COMM      0

// Step prescaler limits
`define MCR_PSC_MAX     4'hF
`define MCR_PSC_MIN     4'h0

`endif

// ---- mcr_pkg.sv ----
// Types shared by the commutation register block and its users.
// Assumes mcr_cfg.svh sits in the include path.
`include "mcr_cfg.svh"

package mcr_pkg;

	// Control bits held in the block's own control register
	typedef struct packed {
		logic [1:0] speed_sensor_select;
		logic       simulated_demag_enable;
		logic       hardware_demag_enable;
		logic       current_mode_select;
		logic       autoswitch_select;
		logic       capture_select_bit;
	} mcr_ctrl_t;

	// One-cycle event pulses from the motor sensing and PWM logic
	typedef struct packed {
		logic pwm_update;
		logic ratio_up;
		logic ratio_down;
		logic current_limit;
		logic emergency;
		logic zero_cross;
		logic demag_end;
		logic commutation;
		logic demag_capture;
	} mcr_evt_t;

	// Bus slave states
	typedef enum logic {MCR_IDLE, MCR_ACK} mcr_bus_t;

endpackage : mcr_pkg

// ---- mcr_regs_irq.sv ----
// Register, multiplier and interrupt-flag logic of a brushless motor
// commutation controller, with an Avalon-MM slave for software.
// Assumes event pulses and capture values come from logic on mclk.
//
// Our own choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`default_nettype none

module mcr_regs_irq
	import mcr_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        reset_n,
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire mcr_evt_t    evt,
	input  wire logic [7:0]  demag_capture_value,
	input  wire logic [7:0]  commutation_timer,
	input  wire logic [7:0]  current_zero_capture,
	input  wire logic [7:0]  previous_zero_capture,
	input  wire logic        cpu_irq_mask,
	output logic      [7:0]  next_commutation_compare,
	output logic      [7:0]  demag_compare,
	output logic      [3:0]  current_mode_rate,
	output logic      [3:0]  prescale_ratio,
	output mcr_ctrl_t        ctrl,
	output logic             pwm_resync,
	output logic             timer_shift_right,
	output logic             timer_shift_left,
	output logic             irq
);

	// Weighted capture divided by 256: keep the product's upper byte
	function automatic logic [7:0] mcr_scale(
		input logic [7:0] capture,
		input logic [7:0] weight
	);
		logic [15:0] product;
		product = capture * weight;
		return product[15:8];
	endfunction : mcr_scale

	mcr_bus_t   bus_state;
	logic [7:0] multiplier_weight;
	logic [7:0] interrupt_enables;
	logic [7:0] interrupt_flags;
	logic       speed_error_flag;
	logic       timer_match_q;

	logic [2:0] idx;
	logic [7:0] wbyte;
	logic       wcommit;
	logic       wr_ncomp;
	logic       wr_demag;
	logic       wr_weight;
	logic       wr_presc;
	logic       wr_irqen;
	logic       wr_flags;
	logic       wr_ctrl;
	logic       wr_aux;
	logic       sensor_mode;
	logic       pending_mode;
	logic       switched_plain;
	logic       resync_wr;
	logic       step_up;
	logic       step_down;
	logic       speed_evt;
	logic [7:0] sel_capture;
	logic [7:0] hw_set;
	logic [7:0] keep_mask;
	logic [7:0] sw_set;
	logic [7:0] consume;
	logic [7:0] eff_enable;
	logic [7:0] read_byte;

	// Bus decode; a write lands on the edge where waitrequest is low
	assign idx       = avs_address[4:2];
	assign wbyte     = avs_writedata[7:0];
	assign wcommit   = (bus_state == MCR_ACK) && avs_write
		&& avs_byteenable[0];
	assign wr_ncomp  = wcommit && (idx == `MCR_IDX_NCOMP);
	assign wr_demag  = wcommit && (idx == `MCR_IDX_DEMAG);
	assign wr_weight = wcommit && (idx == `MCR_IDX_WEIGHT);
	assign wr_presc  = wcommit && (idx == `MCR_IDX_PRESC);
	assign wr_irqen  = wcommit && (idx == `MCR_IDX_IRQEN);
	assign wr_flags  = wcommit && (idx == `MCR_IDX_FLAGS);
	assign wr_ctrl   = wcommit && (idx == `MCR_IDX_CTRL);
	assign wr_aux    = wcommit && (idx == `MCR_IDX_AUX);
	assign resync_wr = wr_flags && (wbyte == `MCR_RESYNC_VAL);

	// Exactly one wait cycle per access, so read data can be flopped
	assign avs_waitrequest = (avs_read || avs_write)
		&& (bus_state != MCR_ACK);

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			bus_state <= MCR_IDLE;
		end else begin
			case (bus_state)
				MCR_IDLE: begin
					if (avs_read || avs_write) begin
						bus_state <= MCR_ACK;
					end
				end
				MCR_ACK: begin
					bus_state <= MCR_IDLE;
				end
				default: begin
					bus_state <= MCR_IDLE;
				end
			endcase
		end
	end

	// Operating modes
	assign sensor_mode    = |ctrl.speed_sensor_select;
	assign pending_mode   = ctrl.autoswitch_select || sensor_mode;
	assign switched_plain = !pending_mode;

	// Prescaler steps: direct events, or flag-driven at commutation.
	// Both flags set in switched mode cancel each other out.
	always_comb begin
		if (pending_mode) begin
			step_up   = evt.ratio_up;
			step_down = evt.ratio_down;
		end else begin
			step_up   = evt.commutation
				&& interrupt_flags[`MCR_B_UP]
				&& !interrupt_flags[`MCR_B_DOWN];
			step_down = evt.commutation
				&& interrupt_flags[`MCR_B_DOWN]
				&& !interrupt_flags[`MCR_B_UP];
		end
	end

	// Capture operand for the commutation delay
	assign sel_capture = ctrl.capture_select_bit
		? current_zero_capture : previous_zero_capture;

	// Next commutation compare; a hardware load beats a bus write
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			next_commutation_compare <= `MCR_RST_BYTE;
		end else if (ctrl.autoswitch_select && evt.zero_cross) begin
			next_commutation_compare <=
				mcr_scale(sel_capture, multiplier_weight);
		end else if (wr_ncomp) begin
			next_commutation_compare <= wbyte;
		end
	end

	// Demag register takes the hardware capture outside sensor mode
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			demag_compare <= `MCR_RST_BYTE;
		end else if (!sensor_mode && ctrl.hardware_demag_enable
			&& evt.demag_capture) begin
			demag_compare <= demag_capture_value;
		end else if (wr_demag) begin
			demag_compare <= wbyte;
		end
	end

	// Plain software registers
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			multiplier_weight <= `MCR_RST_BYTE;
			interrupt_enables <= `MCR_RST_BYTE;
			ctrl              <= mcr_ctrl_t'(7'(`MCR_RST_BYTE));
		end else begin
			if (wr_weight) begin
				multiplier_weight <= wbyte;
			end
			if (wr_irqen) begin
				interrupt_enables <= wbyte;
			end
			if (wr_ctrl) begin
				ctrl <= mcr_ctrl_t'(wbyte[6:0]);
			end
		end
	end

	// Sampling ratio nibble is software only
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			current_mode_rate <= `MCR_PSC_MIN;
		end else if (wr_presc) begin
			current_mode_rate <= wbyte[7:4];
		end
	end

	// Step prescaler saturates rather than wrapping round
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			prescale_ratio <= `MCR_PSC_MIN;
		end else if (step_up) begin
			if (prescale_ratio != `MCR_PSC_MAX) begin
				prescale_ratio <= prescale_ratio + 4'h1;
			end
		end else if (step_down) begin
			if (prescale_ratio != `MCR_PSC_MIN) begin
				prescale_ratio <= prescale_ratio - 4'h1;
			end
		end else if (wr_presc) begin
			prescale_ratio <= wbyte[3:0];
		end
	end

	// Speed error on the cycle the timer first equals the demag value
	assign speed_evt = sensor_mode && !timer_match_q
		&& (commutation_timer == demag_compare);

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			timer_match_q <= 1'b0;
		end else begin
			timer_match_q <= (commutation_timer == demag_compare);
		end
	end

	// Speed error flag: write zero to clear, hardware set wins
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			speed_error_flag <= 1'b0;
		end else if (speed_evt) begin
			speed_error_flag <= 1'b1;
		end else if (wr_aux && !wbyte[0]) begin
			speed_error_flag <= 1'b0;
		end
	end

	// Hardware set sources of the flag register
	always_comb begin
		hw_set                = 8'h00;
		hw_set[`MCR_B_PWM]    = evt.pwm_update || resync_wr;
		hw_set[`MCR_B_UP]     = evt.ratio_up && pending_mode;
		hw_set[`MCR_B_DOWN]   = evt.ratio_down && pending_mode;
		hw_set[`MCR_B_CURRENT_LIMIT_IRQ_ENABLE]   = evt.current_limit
			&& !ctrl.current_mode_select;
		hw_set[`MCR_B_EMER]   = evt.emergency;
		hw_set[`MCR_B_ZERO]   = evt.zero_cross;
		hw_set[`MCR_B_DEMAG]  = evt.demag_end;
		hw_set[`MCR_B_COMM]   = evt.commutation;
	end

	// Software effect on the flags. All ones clears none and sets PWM; otherwise
	// zeros clear. Only in plain switched mode may ratio bits be set.
	always_comb begin
		keep_mask = 8'hFF;
		sw_set    = 8'h00;
		if (wr_flags && !resync_wr) begin
			keep_mask = wbyte;
			if (switched_plain) begin
				sw_set[`MCR_B_UP]   = wbyte[`MCR_B_UP];
				sw_set[`MCR_B_DOWN] = wbyte[`MCR_B_DOWN];
			end
		end
	end

	// Switched mode: ratio requests are used up at the commutation
	always_comb begin
		consume = 8'h00;
		if (switched_plain && evt.commutation) begin
			consume[`MCR_B_UP]   = 1'b1;
			consume[`MCR_B_DOWN] = 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			interrupt_flags <= `MCR_RST_BYTE;
		end else begin
			interrupt_flags <= (((interrupt_flags & keep_mask) | sw_set)
				& ~consume) | hw_set;
		end
	end

	// Pulses to the PWM generator and the commutation timer
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pwm_resync        <= 1'b0;
			timer_shift_right <= 1'b0;
			timer_shift_left  <= 1'b0;
		end else begin
			pwm_resync        <= resync_wr;
			timer_shift_right <= step_up && switched_plain;
			timer_shift_left  <= step_down && switched_plain;
		end
	end

	// Demag end enable needs a demag mode as well
	always_comb begin
		eff_enable = interrupt_enables;
		eff_enable[`MCR_B_DEMAG] = interrupt_enables[`MCR_B_DEMAG]
			&& (ctrl.hardware_demag_enable
			|| ctrl.simulated_demag_enable);
	end

	// Flag bit 6 pairs with the ratio enable at bit 5, and the speed
	// error flag with enable bit 6, so the bit positions differ
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			irq <= 1'b0;
		end else begin
			irq <= !cpu_irq_mask && (
				|(interrupt_flags & eff_enable
					& ~(8'h01 << `MCR_B_UP))
				|| (interrupt_flags[`MCR_B_UP]
					&& eff_enable[`MCR_B_DOWN])
				|| (speed_error_flag
					&& eff_enable[`MCR_B_SPEED]));
		end
	end

	// Read mux; all eight words mapped, the last reads the speed error flag
	always_comb begin
		if (idx == `MCR_IDX_NCOMP) begin
			read_byte = next_commutation_compare;
		end else if (idx == `MCR_IDX_DEMAG) begin
			read_byte = demag_compare;
		end else if (idx == `MCR_IDX_WEIGHT) begin
			read_byte = multiplier_weight;
		end else if (idx == `MCR_IDX_PRESC) begin
			read_byte = {current_mode_rate, prescale_ratio};
		end else if (idx == `MCR_IDX_IRQEN) begin
			read_byte = interrupt_enables;
		end else if (idx == `MCR_IDX_FLAGS) begin
			read_byte = interrupt_flags;
		end else if (idx == `MCR_IDX_CTRL) begin
			read_byte = {1'b0, ctrl};
		end else begin
			read_byte = {7'h00, speed_error_flag};
		end
	end

	// Read data captured in the wait cycle, stands through the answer
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			avs_readdata <= 32'h0000_0000;
		end else if (bus_state == MCR_IDLE && avs_read) begin
			avs_readdata <= {24'h00_0000, read_byte};
		end
	end

endmodule : mcr_regs_irq

`default_nettype wire

// ---- mcr_regs_checker.sv ----
// Port assertions for the commutation register block.
// Assumes one clock, mclk, and reset_n active low; bound to the block.
`timescale 1ns/1ps
`default_nettype none

module mcr_regs_checker
	import mcr_pkg::*;
(
	input wire logic        mclk,
	input wire logic        reset_n,
	input wire logic [4:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire mcr_evt_t    evt,
	input wire logic [7:0]  demag_capture_value,
	input wire logic [7:0]  current_zero_capture,
	input wire logic [7:0]  previous_zero_capture,
	input wire logic        cpu_irq_mask,
	input wire logic [7:0]  next_commutation_compare,
	input wire logic [7:0]  demag_compare,
	input wire mcr_ctrl_t   ctrl,
	input wire logic        pwm_resync,
	input wire logic        timer_shift_right,
	input wire logic        timer_shift_left,
	input wire logic        irq
);
	logic        wr_ok;
	logic        ff_wr;
	logic [7:0]  weight;
	logic [7:0]  opnd;
	logic [15:0] prod;

	// Accepted low-byte write, decoded as the slave decodes it
	assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
	assign ff_wr = wr_ok && avs_address[4:2] == 3'h5
		&& avs_writedata[7:0] == 8'hFF;

	// Shadow weight, since the block does not export it
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			weight <= 8'h00;
		else if (wr_ok && avs_address[4:2] == 3'h2)
			weight <= avs_writedata[7:0];
	end

	// Expected product for the capture that the select bit picks
	assign opnd = ctrl.capture_select_bit ? current_zero_capture
		: previous_zero_capture;
	assign prod = {8'h00, opnd} * {8'h00, weight};

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	a_one_wait_cycle: assert property (
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("Request waited more than one cycle");
	a_irq_cpu_mask: assert property (
		cpu_irq_mask |=> !irq)
		else $error("Interrupt raised while processor mask set");
	a_resync_after_ff: assert property (
		ff_wr |=> pwm_resync)
		else $error("No resync pulse after FF flag write");
	a_resync_cause: assert property (
		pwm_resync |-> $past(ff_wr))
		else $error("Resync pulse without FF flag write");
	a_zero_cross_load: assert property (
		evt.zero_cross && ctrl.autoswitch_select
		|=> next_commutation_compare == $past(prod[15:8]))
		else $error("Compare not loaded with weighted capture");
	a_shift_cause: assert property (
		timer_shift_right || timer_shift_left
		|-> $past(evt.commutation) && !$past(ctrl.autoswitch_select))
		else $error("Timer shift outside switched commutation");
	a_demag_load: assert property (
		evt.demag_capture && ctrl.hardware_demag_enable
		&& ctrl.speed_sensor_select == 2'b00
		|=> demag_compare == $past(demag_capture_value))
		else $error("Demag capture not taken");
	a_read_upper_zero: assert property (
		avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
		else $error("Read data upper bytes not zero");
endmodule : mcr_regs_checker

bind mcr_regs_irq mcr_regs_checker u_chk (.*);

`default_nettype wire

// ---- mcr_motor_model.sv ----
// Far side of the block: sensing and PWM logic that raises events.
// Assumes the bench asks for each event for one mclk cycle.
`timescale 1ns/1ps
`default_nettype none

module mcr_motor_model
	import mcr_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       reset_n,
	input  wire mcr_evt_t   fire,
	input  wire logic [7:0] zc_sample,
	output mcr_evt_t        evt,
	output logic [7:0]      cur_cap,
	output logic [7:0]      prev_cap,
	output logic [7:0]      timer
);
	// Events leave on an edge, as the real sensing logic does
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			evt <= '0;
		else
			evt <= fire;
	end

	// A zero crossing ages the old capture before taking the new one
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cur_cap  <= 8'h00;
			prev_cap <= 8'h00;
		end else if (fire.zero_cross) begin
			prev_cap <= cur_cap;
			cur_cap  <= zc_sample;
		end
	end

	// Free-running step timer
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			timer <= 8'h00;
		else
			timer <= timer + 8'h01;
	end
endmodule : mcr_motor_model

`default_nettype wire

// ---- test_mcr_regs_irq.sv ----
// Self-checking bench for the commutation register block.
// Assumes the checker binds itself and the model supplies events.
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin \
	num_errors++; $display("Error at %0t: got %h expected %h", \
	$time, (got), (exp)); end end

module test_mcr_regs_irq
	import mcr_pkg::*;
;
	logic        mclk = 1'b0;
	logic        reset_n = 1'b0;
	logic [4:0]  avs_address = 5'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	mcr_evt_t    fire = '0;
	mcr_evt_t    evt;
	mcr_ctrl_t   ctrl;
	logic [7:0]  zc_sample = 8'h00;
	logic [7:0]  dv = 8'h00;
	logic [7:0]  cur_cap, prev_cap, timer, ncomp, dcomp, rd;
	logic        cpu_irq_mask = 1'b0;
	logic [3:0]  rate, ratio;
	logic        resync, shr, shl, irq;
	logic [15:0] p;
	int          num_errors = 0;
	int          checks_done = 0;

	always #10 mclk = ~mclk;

	mcr_regs_irq dut (.mclk(mclk), .reset_n(reset_n),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .evt(evt),
		.demag_capture_value(dv), .commutation_timer(timer),
		.current_zero_capture(cur_cap), .previous_zero_capture(prev_cap),
		.cpu_irq_mask(cpu_irq_mask), .next_commutation_compare(ncomp),
		.demag_compare(dcomp), .current_mode_rate(rate),
		.prescale_ratio(ratio), .ctrl(ctrl), .pwm_resync(resync),
		.timer_shift_right(shr), .timer_shift_left(shl), .irq(irq));

	mcr_motor_model u_motor (.mclk(mclk), .reset_n(reset_n), .fire(fire),
		.zc_sample(zc_sample), .evt(evt), .cur_cap(cur_cap),
		.prev_cap(prev_cap), .timer(timer));

	// One bus access, held until waitrequest is seen low at an edge
	task automatic bus(input logic wr, input logic [2:0] idx,
		input logic [7:0] d);
		avs_address <= {idx, 2'b00};
		avs_writedata <= {24'h0, d};
		avs_write <= wr;
		avs_read <= !wr;
		// No cycle limit here: only the watchdog may end a stuck access
		do begin
			@(posedge mclk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata[7:0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge mclk);
	endtask : bus

	task automatic wr(input logic [2:0] idx, input logic [7:0] d);
		bus(1'b1, idx, d);
	endtask : wr

	task automatic rdchk(input logic [2:0] idx, input logic [7:0] e);
		bus(1'b0, idx, 8'h00);
		`CHK(rd, e)
	endtask : rdchk

	// Ask the model for events; flags are visible on return
	task automatic pulse(input mcr_evt_t e);
		fire <= e;
		@(posedge mclk);
		fire <= '0;
		repeat (2) @(posedge mclk);
	endtask : pulse

	task automatic wrap_up();
		if (num_errors == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : wrap_up

	// Whole run is well under a thousand cycles
	initial begin
		repeat (5000) @(posedge mclk);
		num_errors++;
		wrap_up();
	end

	initial begin
		repeat (16) @(posedge mclk);
		reset_n <= 1'b1;
		@(posedge mclk);
		for (int i = 0; i < 8; i++)
			rdchk(3'(i), 8'h00);
		for (int i = 0; i < 5; i++) begin
			wr(3'(i), 8'hA5 - 8'(i));
			rdchk(3'(i), 8'hA5 - 8'(i));
		end
		`CHK({ncomp, dcomp, rate, ratio}, 24'hA5A4A2)
		// Switched mode: ratio flags act at the next commutation
		wr(3'h6, 8'h00);
		wr(3'h3, 8'h35);
		wr(3'h5, 8'h9F);
		wr(3'h5, 8'hBF);
		rdchk(3'h5, 8'h20);
		pulse(9'h002);
		`CHK({rate, ratio}, 8'h34)
		`CHK({shl, shr}, 2'b10)
		wr(3'h5, 8'hDF);
		pulse(9'h002);
		`CHK(ratio, 4'h5)
		`CHK({shl, shr}, 2'b01)
		// Hardware demag capture
		wr(3'h6, 8'h08);
		dv <= 8'h5C;
		pulse(9'h001);
		`CHK(dcomp, 8'h5C)
		// Autoswitched multiplier, current then previous capture
		wr(3'h6, 8'h03);
		wr(3'h5, 8'h00);
		wr(3'h2, 8'hC8);
		zc_sample <= 8'hB4;
		pulse(9'h008);
		p = 16'hB4 * 16'hC8;
		rdchk(3'h0, p[15:8]);
		wr(3'h6, 8'h02);
		wr(3'h2, 8'h40);
		zc_sample <= 8'h10;
		pulse(9'h008);
		p = 16'hB4 * 16'h40;
		`CHK(ncomp, p[15:8])
		// Autoswitched flags: ones ignored, zeros clear, FF resyncs
		rdchk(3'h5, 8'h04);
		wr(3'h5, 8'h7B);
		rdchk(3'h5, 8'h00);
		wr(3'h5, 8'hFF);
		rdchk(3'h5, 8'h80);
		wr(3'h5, 8'h7F);
		rdchk(3'h5, 8'h00);
		// Interrupt follows flag, enable and processor mask
		wr(3'h4, 8'h04);
		pulse(9'h008);
		@(posedge mclk);
		`CHK(irq, 1'b1)
		cpu_irq_mask <= 1'b1;
		repeat (2) @(posedge mclk);
		`CHK(irq, 1'b0)
		cpu_irq_mask <= 1'b0;
		// Simultaneous events, ratio step in autoswitched mode
		wr(3'h5, 8'h00);
		pulse(9'h1B6);
		rdchk(3'h5, 8'hDB);
		`CHK(ratio, 4'h6)
		// Current limit is refused in current mode
		wr(3'h5, 8'h00);
		wr(3'h6, 8'h06);
		pulse(9'h020);
		rdchk(3'h5, 8'h00);
		// Sensor mode: a ratio up event pends, its flag gated by enable bit 5
		wr(3'h6, 8'h20);
		wr(3'h4, 8'h20);
		pulse(9'h080);
		`CHK(ratio, 4'h7)
		@(posedge mclk);
		`CHK(irq, 1'b1)
		rdchk(3'h5, 8'h40);
		wr(3'h5, 8'hBF);
		// Timer reaching the demag value raises the speed error
		wr(3'h4, 8'h40);
		wr(3'h1, 8'h40);
		repeat (260) @(posedge mclk);
		`CHK(irq, 1'b1)
		wr(3'h6, 8'h00);
		rdchk(3'h7, 8'h01);
		wr(3'h7, 8'h00);
		rdchk(3'h7, 8'h00);
		// Demag end interrupt waits for a demag mode
		wr(3'h4, 8'h02);
		pulse(9'h004);
		@(posedge mclk);
		`CHK(irq, 1'b0)
		wr(3'h6, 8'h08);
		@(posedge mclk);
		`CHK(irq, 1'b1)
		wrap_up();
	end
endmodule : test_mcr_regs_irq

`default_nettype wire
